// >>> core/rmc_pkg.sv
// constants, types and command map of the rectifier management command handler
package rmc_pkg;
	// command codes
	localparam logic [7:0] CMD_ONOFF     = 8'h01;
	localparam logic [7:0] CMD_CLEAR     = 8'h03;
	localparam logic [7:0] CMD_WGUARD    = 8'h10;
	localparam logic [7:0] CMD_FACT_ALL  = 8'h12;
	localparam logic [7:0] CMD_FACT_ONE  = 8'h14;
	localparam logic [7:0] CMD_USER_SAVE = 8'h17;
	localparam logic [7:0] CMD_USER_LOAD = 8'h18;
	localparam logic [7:0] CMD_VFORMAT   = 8'h20;
	localparam logic [7:0] CMD_SETPOINT  = 8'h21;
	localparam logic [7:0] CMD_VIN_ON    = 8'h35;
	localparam logic [7:0] CMD_VIN_OFF   = 8'h36;
	localparam logic [7:0] CMD_OV_TRIP   = 8'h40;
	localparam logic [7:0] CMD_OV_ACTION = 8'h41;
	localparam logic [7:0] CMD_OV_WARN   = 8'h42;
	localparam logic [7:0] CMD_UV_WARN   = 8'h43;
	localparam logic [7:0] CMD_UV_TRIP   = 8'h44;
	// data codes
	localparam logic [7:0] ONOFF_ON      = 8'h80;
	localparam logic [7:0] ONOFF_OFF     = 8'h00;
	localparam logic [7:0] WG_ALL        = 8'h00;
	localparam logic [7:0] WG_NONE       = 8'h80;
	localparam logic [7:0] WG_ONOFF      = 8'h40;
	localparam logic [7:0] WG_RESET      = WG_ALL;
	localparam logic [7:0] VFORMAT_VALUE = {3'h0, 5'h17};
	localparam logic [7:0] OV_ACTION_VAL = 8'h80;
	// voltage scaling: mantissa is volts times two to the ninth
	localparam int VOLT_SCALE = 512;
	localparam int SP_DEF_V   = 52;
	localparam int SP_MIN_V   = 17;
	localparam int SP_MAX_V   = 54;
	localparam int LIM_MIN_V  = 16;
	localparam int LIM_MAX_V  = 55;
	localparam int OV_TRIP_V  = 60;
	localparam int OV_WARN_V  = 56;
	localparam int UV_WARN_V  = 41;
	localparam int UV_TRIP_V  = 36;
	localparam logic [15:0] SP_LO  = 16'(SP_MIN_V * VOLT_SCALE);
	localparam logic [15:0] SP_HI  = 16'(SP_MAX_V * VOLT_SCALE);
	localparam logic [15:0] LIM_LO = 16'(LIM_MIN_V * VOLT_SCALE);
	localparam logic [15:0] LIM_HI = 16'(LIM_MAX_V * VOLT_SCALE);
	// operating value slots
	localparam int NVAL = 5;
	localparam logic [2:0] IDX_SP   = 3'h0;
	localparam logic [2:0] IDX_OVT  = 3'h1;
	localparam logic [2:0] IDX_OVW  = 3'h2;
	localparam logic [2:0] IDX_UVW  = 3'h3;
	localparam logic [2:0] IDX_UVT  = 3'h4;
	localparam logic [2:0] IDX_NONE = 3'h7;
	localparam logic [15:0] FACTORY [NVAL] = '{16'(SP_DEF_V * VOLT_SCALE),
		16'(OV_TRIP_V * VOLT_SCALE), 16'(OV_WARN_V * VOLT_SCALE),
		16'(UV_WARN_V * VOLT_SCALE), 16'(UV_TRIP_V * VOLT_SCALE)};
	// status bit positions
	localparam int ST_OV_FAULT = 7;
	localparam int ST_OV_WARN  = 6;
	localparam int ST_UV_WARN  = 5;
	localparam int ST_UV_FAULT = 4;
	// timing: a 1 ms tick drives every slow counter
	localparam int CLK_HZ       = 125_000_000;
	localparam int TICK_US      = 1000;
	localparam int RETRY_S      = 1;
	localparam int WINDOW_S     = 60;
	localparam int OFF_HOLD_S   = 2;
	localparam int TICKS_PER_S  = 1_000_000 / TICK_US;
	localparam int TICK_CYC_DEF = CLK_HZ / 1_000_000 * TICK_US;
	localparam int RETRY_T_DEF  = RETRY_S * TICKS_PER_S;
	localparam int WINDOW_T_DEF = WINDOW_S * TICKS_PER_S;
	localparam int HOLD_T_DEF   = OFF_HOLD_S * TICKS_PER_S;
	localparam logic [1:0] OV_RETRY_MAX = 2'd3;
	// over-voltage retry sequencer
	typedef enum logic [1:0] {SEQ_RUN, SEQ_WAIT, SEQ_LATCHED} rmc_seq_t;
	// one decoded bus transaction from the framer
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        from_ctrl;
		logic        pec_ok;
		logic [7:0]  code;
		logic [15:0] data;
	} rmc_cmd_t;
endpackage

// >>> core/rmc_handler.sv
// command handler, protection sequencer and status for the rectifier management port
// Contract
// - on/off takes 0x80 on or 0x00 off; output on after power-up
// - reset: off held at least 2 s, then on; restart clears alarms
// - clear-faults clears all status and releases the controlling side's alert
// - clear-faults always executes; non-controlling side changes nothing
// - persisting fault bits clear, then set again after clear-faults
// - write guard 00 all, 80 only guard, 40 guard and on/off
// - reads always succeed; writes to write guard always accepted; code refuses reads of unlisted codes and guard data other than 00, 40, 80
// - write guard resets to all-writes and is never saved as user value
// - reload-all restores every operating value from fixed factory defaults
// - reload-one restores one selected value from factory default
// - save-one stores one user default; reload-one-user restores it
// - voltage format reads zero top bits and exponent in low five
// - voltage mantissa 16 bit unsigned, scale 2^-9, low byte first
// - set-point write changes regulated voltage at once; may be saved
// - after set-point write ignore set-point pin until ac input lost
// - turn-on/turn-off level queries depend on low-line or high-line mode
// - output above over-voltage trip limit shuts output; default 60 V
// - over-voltage: three retries 1 s apart, latch if three in 1 min
// - latch released by on/off pin or command cycle; restart clears status
// - output above warning limit raises alert; default 56 V
// - output below under-voltage warning raises alert; default 41 V
// - under-voltage trip shuts output unless overload or input interruption
// - out-of-range limit or set-point keeps old value, flags comm fault
// - every transaction carries a valid packet error code; the handler checks it on writes only
module rmc_handler
	import rmc_pkg::*;
#(
	parameter int unsigned TICK_CYCLES  = TICK_CYC_DEF,
	parameter int unsigned RETRY_TICKS  = RETRY_T_DEF,
	parameter int unsigned WINDOW_TICKS = WINDOW_T_DEF,
	parameter int unsigned HOLD_TICKS   = HOLD_T_DEF,
	parameter logic [15:0] VIN_ON_HL    = 16'h0000,
	parameter logic [15:0] VIN_OFF_HL   = 16'h0000,
	parameter logic [15:0] VIN_ON_LL    = 16'h0000,
	parameter logic [15:0] VIN_OFF_LL   = 16'h0000
)(
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire rmc_cmd_t    CMD,
	input  wire logic        AC_PRESENT,
	input  wire logic        HW_ONOFF_INPUT,
	input  wire logic        LOW_LINE,
	input  wire logic        OVERLOAD,
	input  wire logic        INPUT_INTERRUPT,
	input  wire logic [15:0] VOUT_MEAS,
	input  wire logic [15:0] VPROG_SETPOINT,
	output logic             RSP_VALID,
	output logic             RSP_ACK,
	output logic [15:0]      RSP_DATA,
	output logic             OUTPUT_ENABLE,
	output logic [15:0]      SETPOINT,
	output logic             ALERT_N,
	output logic             COMM_FAULT_FLAG,
	output logic [7:0]       STATUS_VOUT,
	output logic             LATCHED_OFF
);
	logic [7:0]  wg;
	logic        op_on;
	logic        sw_active;
	logic [15:0] op_val [NVAL];
	logic [15:0] user_val [NVAL];
	logic [7:0]  status_vout;
	logic        comm;
	rmc_seq_t    seq;
	logic [1:0]  fails;
	logic        win_run;
	logic [31:0] win_cnt;
	logic [31:0] wait_cnt;
	logic [31:0] tick_cnt;
	logic        tick;
	logic [31:0] off_ticks;
	logic        hw_prev;
	logic [2:0]  wr_idx;
	logic [2:0]  arg_idx;
	logic        cmd_bad;
	logic        next_ack;
	logic [15:0] next_rdata;
	logic        do_onoff, do_clear, do_wguard, do_fact_all, do_fact_one;
	logic        do_save, do_load, do_val, guard_ok;
	logic        restart_ev, clear_ev, ov_now, uv_now;
	logic [7:0]  st_set;

	// which operating slot a command code names
	function automatic logic [2:0] val_index(input logic [7:0] c);
		case (c)
			CMD_SETPOINT: return IDX_SP;
			CMD_OV_TRIP:  return IDX_OVT;
			CMD_OV_WARN:  return IDX_OVW;
			CMD_UV_WARN:  return IDX_UVW;
			CMD_UV_TRIP:  return IDX_UVT;
			default:      return IDX_NONE;
		endcase
	endfunction

	// set-point has a narrower window than the limits
	function automatic logic in_range(input logic [2:0] idx, input logic [15:0] v);
		if (idx == IDX_SP)
			return (v >= SP_LO) && (v <= SP_HI);
		return (v >= LIM_LO) && (v <= LIM_HI);
	endfunction

	// write guard gate; clear-faults is always executable
	// guard code gating
	assign guard_ok = (CMD.code == CMD_WGUARD) || (CMD.code == CMD_CLEAR) || (wg == WG_ALL)
		|| ((wg == WG_ONOFF) && (CMD.code == CMD_ONOFF));

	// command decode and read mux
	always_comb
	begin
		wr_idx = val_index(CMD.code);
		arg_idx = val_index(CMD.data[7:0]);
		cmd_bad = 1'b0;
		next_ack = 1'b0;
		next_rdata = 16'h0000;
		do_onoff = 1'b0;
		do_clear = 1'b0;
		do_wguard = 1'b0;
		do_fact_all = 1'b0;
		do_fact_one = 1'b0;
		do_save = 1'b0;
		do_load = 1'b0;
		do_val = 1'b0;
		if (CMD.valid && CMD.write)
		begin
			if (!CMD.pec_ok)
				cmd_bad = 1'b1;
			else if (!guard_ok)
				cmd_bad = 1'b1;
			else
			begin
				case (CMD.code)
					CMD_ONOFF:
					begin
						if ((CMD.data[7:0] == ONOFF_ON) || (CMD.data[7:0] == ONOFF_OFF))
							do_onoff = 1'b1;
						else
							cmd_bad = 1'b1;
					end
					// foreign side is a quiet no-op
					CMD_CLEAR: do_clear = CMD.from_ctrl;
					CMD_WGUARD:
					begin
						if ((CMD.data[7:0] == WG_ALL) || (CMD.data[7:0] == WG_NONE)
							|| (CMD.data[7:0] == WG_ONOFF))
							do_wguard = 1'b1;
						else
							cmd_bad = 1'b1;
					end
					CMD_FACT_ALL: do_fact_all = 1'b1;
					// guard is no slot, so saving it is refused
					CMD_FACT_ONE, CMD_USER_SAVE, CMD_USER_LOAD:
					begin
						if (arg_idx == IDX_NONE)
							cmd_bad = 1'b1;
						else
						begin
							do_fact_one = (CMD.code == CMD_FACT_ONE);
							do_save = (CMD.code == CMD_USER_SAVE);
							do_load = (CMD.code == CMD_USER_LOAD);
						end
					end
					default:
					begin
						// out of range keeps old value
						if ((wr_idx != IDX_NONE) && in_range(wr_idx, CMD.data))
							do_val = 1'b1;
						else
							cmd_bad = 1'b1;
					end
				endcase
			end
			next_ack = !cmd_bad;
		end
		else if (CMD.valid)
		begin
			next_ack = 1'b1;
			case (CMD.code)
				CMD_ONOFF:     next_rdata = {8'h00, (op_on ? ONOFF_ON : ONOFF_OFF)};
				CMD_WGUARD:    next_rdata = {8'h00, wg};
				CMD_VFORMAT:   next_rdata = {8'h00, VFORMAT_VALUE};
				CMD_SETPOINT:  next_rdata = SETPOINT;
				CMD_VIN_ON:    next_rdata = LOW_LINE ? VIN_ON_LL : VIN_ON_HL;
				CMD_VIN_OFF:   next_rdata = LOW_LINE ? VIN_OFF_LL : VIN_OFF_HL;
				CMD_OV_ACTION: next_rdata = {8'h00, OV_ACTION_VAL};
				CMD_OV_TRIP, CMD_OV_WARN, CMD_UV_WARN, CMD_UV_TRIP:
					next_rdata = op_val[wr_idx];
				default:
				begin
					next_ack = 1'b0;
					cmd_bad = 1'b1;
				end
			endcase
		end
	end

	// answer one cycle after the request; data low byte is the first on the wire
	// mantissa word, framer sends low byte first
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			RSP_VALID <= 1'b0;
			RSP_ACK <= 1'b0;
			RSP_DATA <= 16'h0000;
		end
		else
		begin
			RSP_VALID <= CMD.valid;
			RSP_ACK <= next_ack;
			RSP_DATA <= next_rdata;
		end
	end

	// write guard register
	// resets to all writes
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			wg <= WG_RESET;
		else if (do_wguard)
			wg <= CMD.data[7:0];
	end

	// operating and user values; user copy is not truly non-volatile since RST
	// models ac removal and reloads it, a limitation of holding it in flops
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			op_val <= FACTORY;
			user_val <= FACTORY;
		end
		else
		begin
			if (do_fact_all)
				op_val <= FACTORY;
			if (do_fact_one)
				op_val[arg_idx] <= FACTORY[arg_idx];
			// save and reload one user slot
			if (do_save)
				user_val[arg_idx] <= op_val[arg_idx];
			if (do_load)
				op_val[arg_idx] <= user_val[arg_idx];
			if (do_val)
				op_val[wr_idx] <= CMD.data;
		end
	end

	// software set-point ownership until ac input drops
	// pin ignored after a set-point write
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			sw_active <= 1'b0;
		else if (!AC_PRESENT)
			sw_active <= 1'b0;
		else if ((do_val && wr_idx == IDX_SP)
			|| ((do_load || do_fact_one) && arg_idx == IDX_SP))
			sw_active <= 1'b1;
	end

	// 1 ms tick divider
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			tick_cnt <= 32'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= (tick_cnt == TICK_CYCLES - 1);
			tick_cnt <= (tick_cnt == TICK_CYCLES - 1) ? 32'h0 : tick_cnt + 32'h1;
		end
	end

	// on/off command and how long it has been off
	// powers up on, two codes only
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			op_on <= 1'b1;
			off_ticks <= 32'h0;
			hw_prev <= 1'b1;
		end
		else
		begin
			hw_prev <= HW_ONOFF_INPUT;
			if (do_onoff)
				op_on <= (CMD.data[7:0] == ONOFF_ON);
			if (op_on)
				off_ticks <= 32'h0;
			else if (tick && off_ticks < HOLD_TICKS)
				off_ticks <= off_ticks + 32'h1;
		end
	end

	// on after a long enough off
	assign restart_ev = (do_onoff && CMD.data[7:0] == ONOFF_ON && !op_on
		&& off_ticks >= HOLD_TICKS) || (HW_ONOFF_INPUT && !hw_prev);
	assign clear_ev = do_clear || restart_ev;

	assign ov_now = OUTPUT_ENABLE && (VOUT_MEAS > op_val[IDX_OVT]);
	// under-voltage trip, masked in overload and on input loss
	assign uv_now = OUTPUT_ENABLE && (VOUT_MEAS < op_val[IDX_UVT]) && !OVERLOAD
		&& !INPUT_INTERRUPT;

	// over-voltage retry sequencer with its failure window
	// three failures in the window latch
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			seq <= SEQ_RUN;
			fails <= 2'd0;
			win_run <= 1'b0;
			win_cnt <= 32'h0;
			wait_cnt <= 32'h0;
		end
		else if (restart_ev)
		begin
			seq <= SEQ_RUN;
			fails <= 2'd0;
			win_run <= 1'b0;
			win_cnt <= 32'h0;
		end
		else
		begin
			if (win_run && tick)
				win_cnt <= win_cnt + 32'h1;
			// window over since the first failure: forget the count and start over
			if (win_run && seq != SEQ_LATCHED && win_cnt >= WINDOW_TICKS)
			begin
				win_run <= 1'b0;
				win_cnt <= 32'h0;
				fails <= 2'd0;
			end
			case (seq)
				SEQ_RUN:
				begin
					wait_cnt <= 32'h0;
					if (ov_now)
					begin
						fails <= fails + 2'd1;
						if (!win_run)
						begin
							win_run <= 1'b1;
							win_cnt <= 32'h0;
						end
						seq <= (fails + 2'd1 == OV_RETRY_MAX) ? SEQ_LATCHED : SEQ_WAIT;
					end
					else if (uv_now)
						seq <= SEQ_WAIT;
				end
				SEQ_WAIT:
				begin
					if (tick)
						wait_cnt <= wait_cnt + 32'h1;
					if (wait_cnt >= RETRY_TICKS)
						seq <= SEQ_RUN;
				end
				SEQ_LATCHED: seq <= SEQ_LATCHED;
				default: seq <= SEQ_RUN;
			endcase
		end
	end

	// sticky status sources
	// above warning
	always_comb
	begin
		st_set = 8'h00;
		st_set[ST_OV_FAULT] = ov_now || (seq == SEQ_LATCHED);
		st_set[ST_OV_WARN] = VOUT_MEAS > op_val[IDX_OVW];
		st_set[ST_UV_WARN] = OUTPUT_ENABLE && (VOUT_MEAS < op_val[IDX_UVW]);
		st_set[ST_UV_FAULT] = uv_now;
	end

	// clear empties the bits for one cycle; a fault still present sets them again
	// clear first, re-set after
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			status_vout <= 8'h00;
		else if (clear_ev)
			status_vout <= 8'h00;
		else
			status_vout <= status_vout | st_set;
	end

	// comm fault: a refused command in the clearing cycle still sets it
	// flag refused writes
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
			comm <= 1'b0;
		else
			comm <= cmd_bad || (comm && !clear_ev);
	end

	// registered outputs
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			OUTPUT_ENABLE <= 1'b0;
			SETPOINT <= 16'h0000;
			ALERT_N <= 1'b1;
			COMM_FAULT_FLAG <= 1'b0;
			STATUS_VOUT <= 8'h00;
			LATCHED_OFF <= 1'b0;
		end
		else
		begin
			OUTPUT_ENABLE <= op_on && HW_ONOFF_INPUT && (seq == SEQ_RUN) && !ov_now && !uv_now;
			SETPOINT <= sw_active ? op_val[IDX_SP] : VPROG_SETPOINT;
			ALERT_N <= !((|status_vout) || comm);
			COMM_FAULT_FLAG <= comm;
			STATUS_VOUT <= status_vout;
			LATCHED_OFF <= (seq == SEQ_LATCHED);
		end
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	chk_onoff_reject: assert property (CMD.valid && CMD.write && CMD.pec_ok && guard_ok
		&& CMD.code == CMD_ONOFF && CMD.data[7:0] != ONOFF_ON && CMD.data[7:0] != ONOFF_OFF
		|=> $stable(op_on) && comm) else $error("bad on/off data changed output");
	chk_guard_write: assert property (CMD.valid && CMD.write && CMD.pec_ok
		&& CMD.code == CMD_WGUARD && CMD.data[7:0] == WG_NONE |=> wg == WG_NONE)
		else $error("write guard write not accepted");
	chk_guard_block: assert property (CMD.valid && CMD.write && wg != WG_ALL
		&& CMD.code == CMD_OV_TRIP |=> $stable(op_val[IDX_OVT]) && comm)
		else $error("guarded write changed a limit");
	chk_clear_alert: assert property (do_clear |=> status_vout == 8'h00 && !comm
		##1 ALERT_N) else $error("clear did not release alert");
	chk_foreign_clear: assert property (CMD.valid && CMD.write && CMD.code == CMD_CLEAR
		&& !CMD.from_ctrl && comm && !restart_ev |=> comm)
		else $error("non-controlling clear changed state");
	chk_range_keep: assert property (CMD.valid && CMD.write && CMD.pec_ok && guard_ok
		&& CMD.code == CMD_SETPOINT && !in_range(IDX_SP, CMD.data)
		|=> $stable(op_val[IDX_SP]) && comm) else $error("out-of-range set-point taken");
	chk_latch_count: assert property (seq != SEQ_LATCHED |-> fails < OV_RETRY_MAX)
		else $error("retry count passed limit without latching");
	chk_latch_hold: assert property (seq == SEQ_LATCHED && !restart_ev
		|=> seq == SEQ_LATCHED && LATCHED_OFF) else $error("latched state left without restart");
	chk_ov_shutdown: assert property (ov_now |=> !OUTPUT_ENABLE [*2])
		else $error("output stayed on over trip level");
	chk_pin_setpoint: assert property (!AC_PRESENT ##1 !AC_PRESENT
		|=> SETPOINT == $past(VPROG_SETPOINT)) else $error("set-point pin not followed");
	chk_ov_warn: assert property (VOUT_MEAS > op_val[IDX_OVW] && !clear_ev
		|=> status_vout[ST_OV_WARN] ##1 !ALERT_N) else $error("warning did not alert");
	chk_restart_clear: assert property (restart_ev |=> status_vout == 8'h00 && !comm
		&& seq == SEQ_RUN) else $error("restart left alarms set");
	chk_factory_all: assert property (do_fact_all |=> op_val[IDX_OVT] == FACTORY[IDX_OVT]
		&& op_val[IDX_SP] == FACTORY[IDX_SP]) else $error("factory reload incomplete");

	cov_latch: cover property ($rose(seq == SEQ_LATCHED));
	cov_retry: cover property (seq == SEQ_WAIT ##1 seq == SEQ_RUN);
	cov_restart: cover property (LATCHED_OFF ##1 restart_ev);
	cov_save_load: cover property (do_save ##[1:20] do_load);
endmodule

// >>> verification/rmc_host_model.sv
// host controller model that issues decoded management transactions
module rmc_host_model
	import rmc_pkg::*;
(
	input  wire logic        clock,
	output rmc_cmd_t         cmd,
	input  wire logic        rsp_valid,
	input  wire logic        rsp_ack,
	input  wire logic [15:0] rsp_data
);
	timeunit 1ns;
	timeprecision 1ps;

	// idle bus until the first transaction
	initial cmd = '0;

	// one transaction, answer taken in the cycle the response pulse shows
	task automatic xfer(input logic wr, ctl, pec, input logic [7:0] code, lo, hi,
		output logic ack, output logic [15:0] rd);
		ack = 1'bx;
		rd = 16'hxxxx;
		@(negedge clock);
		cmd <= '{1'b1, wr, ctl, pec, code, {hi, lo}};
		for (int i = 0; i < 3; i++)
		begin
			@(negedge clock);
			// released data inverted so stale values never look valid
			if (i == 0)
				cmd <= '{1'b0, wr, ctl, pec, code, ~{hi, lo}};
			if (rsp_valid === 1'b1)
			begin
				ack = rsp_ack;
				rd = rsp_data;
			end
		end
	endtask
endmodule

// >>> verification/rmc_handler_tb_top.sv
// self-checking bench for the management command handler
module rmc_handler_tb_top;
	import rmc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TK = 4;
	localparam int HT = 3;
	// turn-on and turn-off levels are arbitrary, only need to differ
	localparam logic [15:0] LV [4] = '{16'h1111, 16'h2222, 16'h3333, 16'h4444};
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        ac = 1'b1;
	logic        hw = 1'b1;
	logic        low_line = 1'b0;
	logic        ovl = 1'b0;
	logic        intr = 1'b0;
	logic [15:0] vout = 16'h6000;
	logic [15:0] vprog = 16'h6400;
	rmc_cmd_t    cmd;
	logic        rsp_valid, rsp_ack, out_en, alert_n, comm, latched, ack;
	logic [15:0] rsp_data, setpoint, rd;
	logic [7:0]  status;
	int          mismatches = 0;
	int          samples_checked = 0;

	// short counts keep retry and window spans small
	rmc_handler #(.TICK_CYCLES(TK), .RETRY_TICKS(3), .WINDOW_TICKS(20), .HOLD_TICKS(HT),
		.VIN_ON_HL(LV[0]), .VIN_OFF_HL(LV[1]), .VIN_ON_LL(LV[2]), .VIN_OFF_LL(LV[3]))
	i_rmc_handler (.CLOCK(clock), .RST(rst), .CMD(cmd), .AC_PRESENT(ac),
		.HW_ONOFF_INPUT(hw), .LOW_LINE(low_line), .OVERLOAD(ovl), .INPUT_INTERRUPT(intr),
		.VOUT_MEAS(vout), .VPROG_SETPOINT(vprog), .RSP_VALID(rsp_valid), .RSP_ACK(rsp_ack),
		.RSP_DATA(rsp_data), .OUTPUT_ENABLE(out_en), .SETPOINT(setpoint), .ALERT_N(alert_n),
		.COMM_FAULT_FLAG(comm), .STATUS_VOUT(status), .LATCHED_OFF(latched));
	rmc_host_model i_rmc_host_model (.clock(clock), .cmd(cmd), .rsp_valid(rsp_valid),
		.rsp_ack(rsp_ack), .rsp_data(rsp_data));

	// free running clock
	always #4 clock = ~clock;

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// compare tasks, one for words and one for flags
	task automatic chk(input logic [15:0] got, exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, exp);
		chk({15'h0, got}, {15'h0, exp});
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clock);
	endtask
	task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic eack);
		i_rmc_host_model.xfer(1'b1, 1'b1, 1'b1, code, d[7:0], d[15:8], ack, rd);
		chkb(ack, eack);
	endtask
	task automatic rdchk(input logic [7:0] code, input logic [15:0] exp);
		i_rmc_host_model.xfer(1'b0, 1'b1, 1'b1, code, 8'h00, 8'h00, ack, rd);
		chkb(ack, 1'b1);
		chk(rd, exp);
	endtask

	task automatic t_reset;
		chkb(out_en, 1'b1);
		chk(setpoint, vprog);
		rdchk(CMD_WGUARD, 16'h0000);
		rdchk(CMD_VFORMAT, 16'h0017);
		rdchk(CMD_OV_TRIP, 16'h7800);
		rdchk(CMD_OV_WARN, 16'h7000);
		rdchk(CMD_UV_WARN, 16'h5200);
		rdchk(CMD_UV_TRIP, 16'h4800);
		rdchk(CMD_OV_ACTION, 16'h0080);
		wr(CMD_VFORMAT, 16'h0000, 1'b0);
		wr(CMD_OV_ACTION, 16'h00c0, 1'b0);
		for (int i = 0; i < 2; i++)
		begin
			low_line = i[0];
			rdchk(CMD_VIN_ON, LV[2 * i]);
			rdchk(CMD_VIN_OFF, LV[2 * i + 1]);
		end
	endtask

	task automatic t_setpoint;
		wr(CMD_SETPOINT, 16'h64e6, 1'b1);
		cyc(2);
		chk(setpoint, 16'h64e6);
		vprog = 16'h5000;
		cyc(3);
		chk(setpoint, 16'h64e6);
		wr(CMD_SETPOINT, 16'h2100, 1'b0);
		i_rmc_host_model.xfer(1'b1, 1'b1, 1'b0, CMD_SETPOINT, 8'h00, 8'h30, ack, rd);
		chkb(ack, 1'b0);
		cyc(2);
		chk(setpoint, 16'h64e6);
		chkb(comm, 1'b1);
		ac = 1'b0;
		cyc(3);
		chk(setpoint, 16'h5000);
		ac = 1'b1;
	endtask

	task automatic t_clear;
		chkb(alert_n, 1'b0);
		i_rmc_host_model.xfer(1'b1, 1'b0, 1'b1, CMD_CLEAR, 8'h00, 8'h00, ack, rd);
		chkb(ack, 1'b1);
		cyc(2);
		chkb(comm, 1'b1);
		wr(CMD_CLEAR, 16'h0000, 1'b1);
		cyc(1);
		chkb(comm, 1'b0);
		chkb(alert_n, 1'b1);
		vout = 16'h7200;
		cyc(3);
		chk(16'(status), 16'h0040);
		chkb(alert_n, 1'b0);
		chkb(out_en, 1'b1);
		wr(CMD_CLEAR, 16'h0000, 1'b1);
		cyc(3);
		chk(16'(status), 16'h0040);
		vout = 16'h5000;
		cyc(3);
		chk(16'(status), 16'h0060);
		vout = 16'h6000;
		wr(CMD_CLEAR, 16'h0000, 1'b1);
		cyc(3);
		chk(16'(status), 16'h0000);
	endtask

	task automatic t_guard;
		wr(CMD_ONOFF, 16'h0001, 1'b0);
		chkb(out_en, 1'b1);
		wr(CMD_WGUARD, 16'h0080, 1'b1);
		wr(CMD_SETPOINT, 16'h6000, 1'b0);
		wr(CMD_ONOFF, 16'h0000, 1'b0);
		rdchk(CMD_OV_TRIP, 16'h7800);
		wr(CMD_WGUARD, 16'h0040, 1'b1);
		wr(CMD_OV_TRIP, 16'h6000, 1'b0);
		rdchk(CMD_OV_TRIP, 16'h7800);
		wr(CMD_ONOFF, 16'h0000, 1'b1);
		chkb(out_en, 1'b0);
		wr(CMD_WGUARD, 16'h0020, 1'b0);
		wr(CMD_WGUARD, 16'h0000, 1'b1);
		wr(CMD_ONOFF, 16'h0080, 1'b1);
		cyc(1);
		chkb(out_en, 1'b1);
	endtask

	task automatic t_store;
		wr(CMD_OV_TRIP, 16'h6c00, 1'b1);
		wr(CMD_OV_WARN, 16'h6a00, 1'b1);
		wr(CMD_USER_SAVE, 16'(CMD_OV_WARN), 1'b1);
		wr(CMD_USER_SAVE, 16'(CMD_WGUARD), 1'b0);
		wr(CMD_FACT_ONE, 16'(CMD_OV_WARN), 1'b1);
		rdchk(CMD_OV_WARN, 16'h7000);
		rdchk(CMD_OV_TRIP, 16'h6c00);
		wr(CMD_USER_LOAD, 16'(CMD_OV_WARN), 1'b1);
		rdchk(CMD_OV_WARN, 16'h6a00);
		wr(CMD_FACT_ALL, 16'h0000, 1'b1);
		rdchk(CMD_OV_TRIP, 16'h7800);
		rdchk(CMD_OV_WARN, 16'h7000);
	endtask

	task automatic t_ov;
		vout = 16'h7a00;
		cyc(2);
		chkb(out_en, 1'b0);
		chk(16'(status), 16'h00c0);
		vout = 16'h6000;
		cyc(4);
		chkb(out_en, 1'b0);
		cyc(14);
		chkb(out_en, 1'b1);
		vout = 16'h7a00;
		cyc(40);
		chkb(latched, 1'b1);
		vout = 16'h6000;
		cyc(20);
		chkb(out_en, 1'b0);
		// host keeps the output off past the hold before asking it on
		wr(CMD_ONOFF, 16'h0000, 1'b1);
		cyc(HT * TK + 8);
		wr(CMD_ONOFF, 16'h0080, 1'b1);
		cyc(2);
		chkb(latched, 1'b0);
		chkb(out_en, 1'b1);
		chk(16'(status), 16'h0000);
		// clear-faults is write-only, so a read of it is refused and flags comm fault
		i_rmc_host_model.xfer(1'b0, 1'b1, 1'b1, CMD_CLEAR, 8'h00, 8'h00, ack, rd);
		chkb(ack, 1'b0);
		chk(rd, 16'h0000);
		chkb(comm, 1'b1);
		hw = 1'b0;
		cyc(3);
		hw = 1'b1;
		cyc(3);
		chkb(comm, 1'b0);
		chkb(out_en, 1'b1);
	endtask

	task automatic t_uv;
		vout = 16'h4600;
		ovl = 1'b1;
		cyc(4);
		chkb(out_en, 1'b1);
		ovl = 1'b0;
		intr = 1'b1;
		cyc(4);
		chkb(out_en, 1'b1);
		intr = 1'b0;
		cyc(3);
		chkb(out_en, 1'b0);
		chk(16'(status), 16'h0030);
		vout = 16'h6000;
		cyc(20);
		chkb(out_en, 1'b1);
	endtask

	// main sequence
	initial
	begin
		cyc(3);
		rst = 1'b0;
		cyc(2);
		t_reset;
		t_setpoint;
		t_clear;
		t_guard;
		t_store;
		t_ov;
		t_uv;
		tally_and_finish;
	end

	// watchdog, well beyond the expected run length
	initial
	begin
		repeat (5000) @(posedge clock);
		mismatches++;
		tally_and_finish;
	end
endmodule
